// file: logic/dvi_top.sv
/*
 * interrupt vectoring and prioritisation for the dsp core: pending
 * flags, enable mask, vector and priority offer to the core, axi4-lite
 * register slave and one level interrupt line.
 * assumes: pins are asynchronous and active low; peripheral requests
 * are one-cycle pulses on ref_clk; the core answers an offer with a
 * one-cycle core_accept pulse.
 */
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module dvi_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire dvi_pkg::dvi_axi_req_s axi_req,
    output dvi_pkg::dvi_axi_rsp_s axi_rsp,
    input wire logic hardware_reset_pin_n,
    input wire logic nmi_pin_n,
    input wire logic external_request_0_n,
    input wire logic external_request_1_n,
    input wire logic external_request_2_n,
    input wire logic external_request_3_n,
    input wire logic timer_request,
    input wire logic port0_receive_request,
    input wire logic port0_transmit_request,
    input wire logic port1_receive_request,
    input wire logic port1_transmit_request,
    input wire logic port2_receive_request,
    input wire logic port2_transmit_request,
    input wire logic host_port_request,
    input wire logic dma_channel4_request,
    input wire logic dma_channel5_request,
    input wire logic software_reset_trap,
    input wire logic software_trap_valid,
    input wire logic [4:0] software_trap_number,
    input wire logic core_accept,
    output dvi_pkg::dvi_offer_s core_offer,
    output logic irq
);
    import dvi_pkg::*;

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    function automatic logic [VECW-1:0] mask_vector(
        input logic [IDXW-1:0] idx
    );
        mask_vector = VEC_MASK_BASE + {1'b0, idx, 2'b00};
    endfunction : mask_vector

    // {ok, vector}; trap 16 goes the nmi way, 14, 15 and 31 are void
    function automatic logic [VECW:0] trap_decode(input logic [4:0] num);
        logic [VECW:0] res;
        res = '0;
        if (num <= TRAP_MASK_LAST) begin
            res = {1'b1, mask_vector(num[IDXW-1:0])};
        end else if (num >= TRAP_FIRST && num <= TRAP_LAST) begin
            res = {1'b1,
                VEC_TRAP_FIRST + {num - TRAP_FIRST, 2'b00}};
        end
        trap_decode = res;
    endfunction : trap_decode

    function automatic logic addr_known(input logic [AXI_AW-1:0] a);
        addr_known = (a == ADDR_FLAGS) || (a == ADDR_MASK) ||
            (a == ADDR_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction : addr_known

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] pin_fall;

    assign pin_raw = {hardware_reset_pin_n, nmi_pin_n,
        external_request_3_n, external_request_2_n,
        external_request_1_n, external_request_0_n};
    assign pin_fall = pin_prev & ~pin_sync;

    // idle pins read high, so reset to ones avoids a false edge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= '1;
            pin_sync <= '1;
            pin_prev <= '1;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ****************************************************************
    // source events in flag bit order
    // ****************************************************************
    logic [NSRC-1:0] src_event;

    always_comb begin
        src_event = '0;
        src_event[BIT_EXT0] = pin_fall[PIN_EXT0];
        src_event[BIT_EXT1] = pin_fall[PIN_EXT1];
        src_event[BIT_EXT2] = pin_fall[PIN_EXT2];
        src_event[BIT_TIMER] = timer_request;
        src_event[BIT_P0_RX] = port0_receive_request;
        src_event[BIT_P0_TX] = port0_transmit_request;
        src_event[BIT_P2_RX] = port2_receive_request;
        src_event[BIT_P2_TX] = port2_transmit_request;
        src_event[BIT_EXT3] = pin_fall[PIN_EXT3];
        src_event[BIT_HOST] = host_port_request;
        src_event[BIT_P1_RX] = port1_receive_request;
        src_event[BIT_P1_TX] = port1_transmit_request;
        src_event[BIT_DMA4] = dma_channel4_request;
        src_event[BIT_DMA5] = dma_channel5_request;
    end

    // ****************************************************************
    // offer engine
    // ****************************************************************
    typedef enum logic [0:0] {OFFER_IDLE, OFFER_WAIT} dvi_offer_e;
    typedef enum logic [1:0] {
        KIND_RESET, KIND_NMI, KIND_TRAP, KIND_MASK
    } dvi_kind_e;

    dvi_offer_e state;
    dvi_offer_e next_state;
    dvi_kind_e kind;
    dvi_kind_e next_kind;
    logic [IDXW-1:0] kind_bit;
    logic [IDXW-1:0] next_kind_bit;
    logic reset_pending;
    logic next_reset_pending;
    logic nmi_pending;
    logic next_nmi_pending;
    logic trap_pending;
    logic next_trap_pending;
    logic [VECW-1:0] trap_vec;
    logic [VECW-1:0] next_trap_vec;
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] next_flags;
    logic [NSRC-1:0] mask;
    logic [NSRC-1:0] next_mask;
    logic [NSRC-1:0] flag_w1c;
    dvi_offer_s next_offer;
    logic [2:0] st_event;
    logic sel_found;
    logic [IDXW-1:0] sel_index;
    logic [VECW:0] trap_dec;

    dvi_prio #(
        .WIDTH(NSRC),
        .IW(IDXW)
    ) u_prio (
        .request(flags & mask),
        .found(sel_found),
        .index(sel_index)
    );

    assign trap_dec = trap_decode(software_trap_number);

    always_comb begin
        next_state = state;
        next_kind = kind;
        next_kind_bit = kind_bit;
        next_reset_pending = reset_pending;
        next_nmi_pending = nmi_pending;
        next_trap_pending = trap_pending;
        next_trap_vec = trap_vec;
        next_offer = core_offer;
        next_flags = flags & ~flag_w1c;
        st_event = '0;

        // clearing by acceptance comes first so a new reset, nmi or flag event wins
        if (state == OFFER_WAIT && core_accept) begin
            next_state = OFFER_IDLE;
            next_offer.valid = 1'b0;
            unique case (kind)
                KIND_RESET: begin
                    next_reset_pending = 1'b0;
                    next_nmi_pending = 1'b0;
                    next_trap_pending = 1'b0;
                    next_flags = '0;
                end
                KIND_NMI: next_nmi_pending = 1'b0;
                KIND_TRAP: next_trap_pending = 1'b0;
                KIND_MASK: next_flags[kind_bit] = 1'b0;
            endcase
        end else if (state == OFFER_IDLE) begin
            // the offer is held stable until the core takes it
            if (reset_pending) begin
                next_state = OFFER_WAIT;
                next_kind = KIND_RESET;
                next_offer = {1'b1, VEC_RESET, PRIO_RESET};
            end else if (nmi_pending) begin
                next_state = OFFER_WAIT;
                next_kind = KIND_NMI;
                next_offer = {1'b1, VEC_NMI, PRIO_NMI};
            end else if (trap_pending) begin
                next_state = OFFER_WAIT;
                next_kind = KIND_TRAP;
                next_offer = {1'b1, trap_vec, PRIO_NONE};
            end else if (sel_found) begin
                next_state = OFFER_WAIT;
                next_kind = KIND_MASK;
                next_kind_bit = sel_index;
                next_offer.valid = 1'b1;
                next_offer.vector = mask_vector(sel_index);
                next_offer.priority_level = PRIO_MASK_BASE
                    + {1'b0, sel_index};
            end
        end

        if (pin_fall[PIN_RST] || software_reset_trap) begin
            next_reset_pending = 1'b1;
            st_event[ST_RESET] = 1'b1;
        end
        // nmi ignores the mask entirely
        if (pin_fall[PIN_NMI] || (software_trap_valid
                && software_trap_number == TRAP_NMI)) begin
            next_nmi_pending = 1'b1;
            st_event[ST_NMI] = 1'b1;
        end
        // a second trap while one waits is dropped
        if (software_trap_valid && trap_dec[VECW] && !trap_pending) begin
            next_trap_pending = 1'b1;
            next_trap_vec = trap_dec[VECW-1:0];
        end
        next_flags = next_flags | src_event;
        st_event[ST_FLAG] = |src_event;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= OFFER_IDLE;
            kind <= KIND_RESET;
            kind_bit <= '0;
            reset_pending <= 1'b0;
            nmi_pending <= 1'b0;
            trap_pending <= 1'b0;
            trap_vec <= '0;
            flags <= FLAGS_RESET;
            core_offer <= '0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            kind_bit <= next_kind_bit;
            reset_pending <= next_reset_pending;
            nmi_pending <= next_nmi_pending;
            trap_pending <= next_trap_pending;
            trap_vec <= next_trap_vec;
            flags <= next_flags;
            core_offer <= next_offer;
        end
    end

    // ****************************************************************
    // axi4-lite slave and interrupt line
    // ****************************************************************
    logic [2:0] status;
    logic [2:0] next_status;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;
    logic next_irq;
    dvi_axi_rsp_s next_rsp;
    logic [REGW-1:0] lane_mask;
    logic [REGW-1:0] wr_bits;
    logic wr_fire;
    logic rd_fire;

    assign lane_mask = {{8{axi_req.wstrb[1]}}, {8{axi_req.wstrb[0]}}};
    assign wr_bits = axi_req.wdata[REGW-1:0] & lane_mask;
    // address and data are taken together, in the same cycle
    assign wr_fire = axi_rsp.awready && axi_req.awvalid;
    assign rd_fire = axi_rsp.arready && axi_req.arvalid;
    assign flag_w1c = (wr_fire && axi_req.awaddr == ADDR_FLAGS)
        ? wr_bits[NSRC-1:0] : '0;

    always_comb begin
        next_rsp = axi_rsp;
        next_mask = mask;
        next_irq_mask = irq_mask;
        next_status = status;
        next_rsp.awready = 1'b0;
        next_rsp.wready = 1'b0;
        next_rsp.arready = 1'b0;

        if (axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid
                && !axi_rsp.awready) begin
            next_rsp.awready = 1'b1;
            next_rsp.wready = 1'b1;
        end
        if (axi_rsp.bvalid && axi_req.bready) begin
            next_rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = addr_known(axi_req.awaddr)
                ? RESP_OKAY : RESP_DECERR;
            if (axi_req.awaddr == ADDR_MASK) begin
                next_mask = (mask & ~lane_mask[NSRC-1:0])
                    | wr_bits[NSRC-1:0];
            end
            if (axi_req.awaddr == ADDR_IRQ_MASK) begin
                next_irq_mask = (irq_mask & ~lane_mask[2:0])
                    | wr_bits[2:0];
            end
            if (axi_req.awaddr == ADDR_STATUS) begin
                next_status = status & ~wr_bits[2:0];
            end
        end
        // hardware events win over a software clear in the same cycle
        next_status = next_status | st_event;

        if (axi_req.arvalid && !axi_rsp.rvalid && !axi_rsp.arready) begin
            next_rsp.arready = 1'b1;
        end
        if (axi_rsp.rvalid && axi_req.rready) begin
            next_rsp.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rsp.rvalid = 1'b1;
            next_rsp.rresp = addr_known(axi_req.araddr)
                ? RESP_OKAY : RESP_DECERR;
            // reserved bits 15-14 and above read as zero
            unique case (axi_req.araddr)
                ADDR_FLAGS: next_rsp.rdata = {18'h00000, flags};
                ADDR_MASK: next_rsp.rdata = {18'h00000, mask};
                ADDR_STATUS: next_rsp.rdata = {29'h00000000, status};
                ADDR_IRQ_MASK: next_rsp.rdata = {29'h00000000, irq_mask};
                default: next_rsp.rdata = 32'h00000000;
            endcase
        end
        next_irq = |(next_status & next_irq_mask);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            axi_rsp <= '0;
            mask <= MASK_RESET;
            irq_mask <= IRQ_MASK_RESET;
            status <= STATUS_RESET;
            irq <= 1'b0;
        end else begin
            axi_rsp <= next_rsp;
            mask <= next_mask;
            irq_mask <= next_irq_mask;
            status <= next_status;
            irq <= next_irq;
        end
    end

endmodule : dvi_top

// file: common/dvi_pkg.sv
/*
 * constants, field positions and carrier structs for the dsp interrupt
 * vectoring block.
 * assumes: a 32-bit axi4-lite master and a core that takes vectored
 * interrupts by a one-cycle accept pulse.
 */
package dvi_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NSRC = 14;
    localparam int IDXW = 4;
    localparam int REGW = 16;
    localparam int AXI_AW = 8;
    localparam int VECW = 7;
    localparam int PRIW = 5;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [AXI_AW-1:0] ADDR_FLAGS = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_MASK = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK = 8'h0c;

    // reset values
    localparam logic [NSRC-1:0] FLAGS_RESET = 14'h0000;
    localparam logic [NSRC-1:0] MASK_RESET = 14'h0000;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // ****************************************************************
    // flag and mask bit positions; bits 15-14 reserved
    // ****************************************************************
    localparam int BIT_EXT0 = 0;
    localparam int BIT_EXT1 = 1;
    localparam int BIT_EXT2 = 2;
    localparam int BIT_TIMER = 3;
    localparam int BIT_P0_RX = 4;
    localparam int BIT_P0_TX = 5;
    localparam int BIT_P2_RX = 6;
    localparam int BIT_P2_TX = 7;
    localparam int BIT_EXT3 = 8;
    localparam int BIT_HOST = 9;
    localparam int BIT_P1_RX = 10;
    localparam int BIT_P1_TX = 11;
    localparam int BIT_DMA4 = 12;
    localparam int BIT_DMA5 = 13;

    // status bits of the interrupt register
    localparam int ST_RESET = 0;
    localparam int ST_NMI = 1;
    localparam int ST_FLAG = 2;

    // synchroniser lanes
    localparam int NPIN = 6;
    localparam int PIN_EXT0 = 0;
    localparam int PIN_EXT1 = 1;
    localparam int PIN_EXT2 = 2;
    localparam int PIN_EXT3 = 3;
    localparam int PIN_NMI = 4;
    localparam int PIN_RST = 5;

    // ****************************************************************
    // vector offsets and priorities
    // ****************************************************************
    localparam logic [VECW-1:0] VEC_RESET = 7'h00;
    localparam logic [VECW-1:0] VEC_NMI = 7'h04;
    localparam logic [VECW-1:0] VEC_TRAP_FIRST = 7'h08;
    localparam logic [VECW-1:0] VEC_MASK_BASE = 7'h40;
    localparam logic [PRIW-1:0] PRIO_RESET = 5'h01;
    localparam logic [PRIW-1:0] PRIO_NMI = 5'h02;
    localparam logic [PRIW-1:0] PRIO_MASK_BASE = 5'h03;
    localparam logic [PRIW-1:0] PRIO_NONE = 5'h00;

    // software trap numbers
    localparam logic [4:0] TRAP_MASK_LAST = 5'h0d;
    localparam logic [4:0] TRAP_NMI = 5'h10;
    localparam logic [4:0] TRAP_FIRST = 5'h11;
    localparam logic [4:0] TRAP_LAST = 5'h1e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } dvi_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dvi_axi_rsp_s;

    typedef struct packed {
        logic valid;
        logic [VECW-1:0] vector;
        logic [PRIW-1:0] priority_level;
    } dvi_offer_s;

endpackage : dvi_pkg

// file: logic/dvi_prio.sv
/*
 * fixed priority picker: lowest set bit wins.
 * assumes: bit order equals priority order of the requests.
 */
`timescale 1ns/10ps
module dvi_prio #(
    parameter int WIDTH = 14,
    parameter int IW = 4
) (
    input wire logic [WIDTH-1:0] request,
    output logic found,
    output logic [IW-1:0] index
);

    // scan downward so the lowest set bit is the last to be written
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (request[i]) begin
                found = 1'b1;
                index = IW'(i);
            end
        end
    end

endmodule : dvi_prio

// file: tb/dvi_checker_assertions.sv
/*
 * concurrent checks on the vector offer and register answers.
 * assumes: bound into dvi_top, one clock, async active-low reset.
 */
`timescale 1ns/10ps
module dvi_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire dvi_pkg::dvi_axi_rsp_s axi_rsp,
    input wire logic nmi_pin_n,
    input wire logic core_accept,
    input wire dvi_pkg::dvi_offer_s core_offer
);
    import dvi_pkg::*;
    // ****************************************
    // offer and bus checks
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire v = core_offer.valid;
    wire [4:0] pl = core_offer.priority_level;
    wire [6:0] vec = core_offer.vector;

    a_reset_slot: assert property (v && pl == 5'h01
        |-> vec == 7'h00)
        else $error("reset offer off its slot");
    a_nmi_slot: assert property (v && pl == 5'h02
        |-> vec == 7'h04)
        else $error("nmi offer off its slot");
    a_mask_slot: assert property (v && pl >= 5'h03
        |-> vec == 7'h40 + {pl - 5'h03, 2'b00})
        else $error("maskable slot does not match priority");
    a_slot_align: assert property (v
        |-> vec[1:0] == 2'b00 && vec < 7'h78)
        else $error("slot misaligned or reserved");
    a_trap_slot: assert property (v && pl == 5'h00
        |-> vec >= 7'h08)
        else $error("trap offer below trap area");
    a_offer_hold: assert property (v && !core_accept
        |=> $stable(core_offer))
        else $error("offer changed while waiting");
    a_accept_drop: assert property (v && core_accept |=> !v)
        else $error("offer stands after accept");
    // nmi ignores the mask
    a_nmi_unmasked: assert property ($fell(nmi_pin_n)
        |-> ##[1:20] (v && pl == 5'h02))
        else $error("nmi not offered");
    a_read_upper: assert property (axi_rsp.rvalid
        |-> axi_rsp.rdata[31:14] == 18'h00000)
        else $error("reserved read bits set");
    a_write_answer: assert property (axi_rsp.awready
        |=> axi_rsp.bvalid)
        else $error("write answer late");

    c_accept: cover property (v && core_accept);
    c_reset_offer: cover property (v && pl == 5'h01);
    c_decerr: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_DECERR);
endmodule : dvi_checker

bind dvi_top dvi_checker i_chk (.ref_clk, .reset_n, .axi_rsp, .nmi_pin_n,
    .core_accept, .core_offer);

// file: tb/dvi_core_model.sv
/*
 * core model: takes each offer after a chosen delay, keeps the last one.
 * assumes: offer stands until accept and drops the edge after.
 */
`timescale 1ns/10ps
module dvi_core_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire dvi_pkg::dvi_offer_s core_offer,
    input wire logic take_en,
    input wire logic [1:0] delay,
    output logic core_accept,
    output dvi_pkg::dvi_offer_s last,
    output int n_taken
);
    import dvi_pkg::*;
    // ****************************************
    // accept logic
    // ****************************************
    logic [1:0] cnt;
    // a slow core leaves the offer standing so holding can be seen
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_accept <= 1'b0;
            cnt <= 2'h0;
            last <= '0;
            n_taken <= 0;
        end else begin
            core_accept <= 1'b0;
            if (core_accept) begin
                cnt <= 2'h0;
            end else if (core_offer.valid && take_en) begin
                if (cnt >= delay) begin
                    core_accept <= 1'b1;
                    last <= core_offer;
                    n_taken <= n_taken + 1;
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule : dvi_core_model

// file: tb/test_dsp_interrupt_vectoring.sv
/*
 * self-checking bench for dvi_top with a core model.
 * assumes: 40 MHz clock, axi4-lite register map of the package.
 */
`timescale 1ns/10ps
module test_dsp_interrupt_vectoring;
    import dvi_pkg::*;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic ref_clk;
    logic reset_n;
    dvi_axi_req_s req;
    dvi_axi_rsp_s rsp;
    logic [NPIN-1:0] pin_n;
    logic [NSRC-1:0] ev;
    logic srst, tv, acc, take_en, irq;
    logic [4:0] tn;
    logic [1:0] dly;
    dvi_offer_s offer, last;
    int n_taken, seen, num_errors, n_checks;
    int cyc = 0;

    dvi_top i_dut (.ref_clk, .reset_n, .axi_req(req), .axi_rsp(rsp),
        .hardware_reset_pin_n(pin_n[PIN_RST]), .nmi_pin_n(pin_n[PIN_NMI]),
        .external_request_0_n(pin_n[PIN_EXT0]),
        .external_request_1_n(pin_n[PIN_EXT1]),
        .external_request_2_n(pin_n[PIN_EXT2]),
        .external_request_3_n(pin_n[PIN_EXT3]),
        .timer_request(ev[BIT_TIMER]),
        .port0_receive_request(ev[BIT_P0_RX]),
        .port0_transmit_request(ev[BIT_P0_TX]),
        .port1_receive_request(ev[BIT_P1_RX]),
        .port1_transmit_request(ev[BIT_P1_TX]),
        .port2_receive_request(ev[BIT_P2_RX]),
        .port2_transmit_request(ev[BIT_P2_TX]),
        .host_port_request(ev[BIT_HOST]),
        .dma_channel4_request(ev[BIT_DMA4]),
        .dma_channel5_request(ev[BIT_DMA5]),
        .software_reset_trap(srst), .software_trap_valid(tv),
        .software_trap_number(tn), .core_accept(acc),
        .core_offer(offer), .irq);
    dvi_core_model i_core (.ref_clk, .reset_n, .core_offer(offer), .take_en,
        .delay(dly), .core_accept(acc), .last, .n_taken);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        @(posedge ref_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {16'h0000, d};
        req.bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.awready) begin
                req.awvalid <= 1'b0;
                req.wvalid <= 1'b0;
            end
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
        chk("bresp", r, rsp.bresp);
    endtask : wr

    task rdr(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r);
        @(posedge ref_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
        chk("rresp", r, rsp.rresp);
        chk("rdata", e, rsp.rdata);
    endtask : rdr

    task take(input logic [6:0] v, input logic [4:0] p);
        while (n_taken == seen) @(posedge ref_clk);
        seen++;
        chk("vector", v, last.vector);
        chk("priority", p, last.priority_level);
    endtask : take

    task pulse(input int k);
        @(posedge ref_clk);
        pin_n[k] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pin_n[k] <= 1'b1;
    endtask : pulse

    task fire(input int b);
        if (b < 3 || b == 8) begin
            pulse(b == 8 ? PIN_EXT3 : b);
        end else begin
            @(posedge ref_clk);
            ev[b] <= 1'b1;
            @(posedge ref_clk);
            ev[b] <= 1'b0;
        end
    endtask : fire

    task swt(input logic [4:0] n);
        @(posedge ref_clk);
        tv <= 1'b1;
        tn <= n;
        @(posedge ref_clk);
        tv <= 1'b0;
    endtask : swt

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rdr(ADDR_FLAGS, 16'h0000, RESP_OKAY);
        rdr(ADDR_MASK, 16'h0000, RESP_OKAY);
        wr(ADDR_MASK, 16'hffff, RESP_OKAY);
        rdr(ADDR_MASK, 16'h3fff, RESP_OKAY);
        wr(8'h10, 16'hffff, RESP_DECERR);
        rdr(8'h10, 16'h0000, RESP_DECERR);
    endtask : t_regs

    task t_table;
        for (int b = 0; b < NSRC; b++) begin
            fire(b);
            take(7'h40 + 7'(4 * b), 5'h03 + 5'(b));
        end
        rdr(ADDR_FLAGS, 16'h0000, RESP_OKAY);
    endtask : t_table

    task t_mask;
        wr(ADDR_MASK, 16'h0000, RESP_OKAY);
        wr(ADDR_STATUS, 16'h0007, RESP_OKAY);
        take_en <= 1'b0;
        fire(BIT_TIMER);
        fire(BIT_DMA5);
        fire(BIT_HOST);
        repeat (4) @(posedge ref_clk);
        chk("offer valid", 0, offer.valid);
        wr(ADDR_FLAGS, 16'h0200, RESP_OKAY);
        rdr(ADDR_FLAGS, 16'h2008, RESP_OKAY);
        chk("irq masked", 0, irq);
        wr(ADDR_IRQ_MASK, 16'h0004, RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        chk("irq", 1, irq);
        wr(ADDR_MASK, 16'h2008, RESP_OKAY);
        repeat (3) @(posedge ref_clk);
        chk("first vector", 7'h4c, offer.vector);
        take_en <= 1'b1;
        take(7'h4c, 5'h06);
        take(7'h74, 5'h10);
        wr(ADDR_STATUS, 16'h0004, RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        chk("irq clear", 0, irq);
    endtask : t_mask

    task t_nmi;
        wr(ADDR_MASK, 16'h0000, RESP_OKAY);
        pulse(PIN_NMI);
        take(7'h04, 5'h02);
        swt(5'h10);
        take(7'h04, 5'h02);
        swt(5'h05);
        take(7'h54, 5'h00);
        for (int n = 17; n <= 30; n++) begin
            swt(5'(n));
            take(7'h08 + 7'(4 * (n - 17)), 5'h00);
        end
    endtask : t_nmi

    task t_reset;
        pulse(PIN_RST);
        take(7'h00, 5'h01);
        take_en <= 1'b0;
        @(posedge ref_clk);
        srst <= 1'b1;
        tv <= 1'b1;
        tn <= 5'h10;
        @(posedge ref_clk);
        srst <= 1'b0;
        tv <= 1'b0;
        take_en <= 1'b1;
        take(7'h00, 5'h01);
    endtask : t_reset

    task give_verdict;
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict;
        end
    end

    initial begin
        reset_n = 1'b0;
        req = '0;
        req.wstrb = 4'hf;
        pin_n = '1;
        ev = '0;
        srst = 1'b0;
        tv = 1'b0;
        tn = 5'h00;
        take_en = 1'b1;
        dly = 2'h0;
        seen = 0;
        num_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs;
        t_table;
        t_mask;
        dly <= 2'h2;
        t_nmi;
        t_reset;
        give_verdict;
    end
endmodule : test_dsp_interrupt_vectoring
